/* File: logic/mif_pkg.sv */
/*
 * Package for the masked interrupt flag controller: register indices,
 * field positions, reset values and the bundled request vector type.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package mif_pkg;

    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [7:0] ADDR_PORT_FLAGS     = 8'h00;
    localparam logic [7:0] ADDR_TIMEBASE_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_COUNTER_FLAGS  = 8'h08;
    localparam logic [7:0] ADDR_PORT_MASKS     = 8'h0C;
    localparam logic [7:0] ADDR_TIMEBASE_MASKS = 8'h10;
    localparam logic [7:0] ADDR_COUNTER_MASKS  = 8'h14;
    localparam logic [7:0] ADDR_SYS_CONTROL    = 8'h18;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         NUM_GROUPS        = 3;
    localparam int         GROUP_WIDTH       = 4;
    localparam int         GLOBAL_EN_BIT     = 0;
    localparam logic [3:0] FLAGS_RESET       = 4'h0;
    localparam logic [3:0] MASKS_RESET       = 4'h0;
    localparam logic       GLOBAL_EN_RESET   = 1'b0;

    // request group indices
    localparam int GRP_PORT     = 0;
    localparam int GRP_TIMEBASE = 1;
    localparam int GRP_COUNTER  = 2;

    // ************************************************************
    // request source bundle from the peripheral cells
    // ************************************************************
    typedef struct packed {
        logic [3:0] port_input;         // port A inputs 3..0
        logic       one_hertz;
        logic       fast_tick;
        logic       blink_tick;
        logic       comparator;         // compare input request
        logic       supply_check;       // supply level detector request
        logic       msec_counter;
        logic       counter_zero;
        logic       counter_match;
    } mif_sources_s;

endpackage : mif_pkg

/* File: logic/mif_edge_flags.sv */
/*
 * One group of four request flags with rising-edge capture and masking.
 * Assumes requests are synchronous to clk_i and that clear strobes come
 * from the register slave as single-cycle pulses.
 */
`timescale 1ns/100ps
module mif_edge_flags
    import mif_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] request_i,
    input  wire logic [3:0] request_mask_i,
    input  wire logic       read_clear_i,
    input  wire logic [3:0] flag_clear_write_i,
    output logic      [3:0] request_flag_o
);

    // ************************************************************
    // edge detection
    // ************************************************************
    logic [3:0] request_prev;
    logic [3:0] rise;
    logic [3:0] next_flag;

    // previous level held so only a low-to-high change counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_prev <= 4'h0;
        end else begin
            request_prev <= request_i;
        end
    end

    // a level or falling edge never sets, and a masked edge is dropped
    assign rise = request_i & ~request_prev & request_mask_i;

    // ************************************************************
    // flag storage
    // ************************************************************
    // clear first, then set, so a coincident edge survives the clear
    always_comb begin
        next_flag = request_flag_o;
        if (read_clear_i) begin
            next_flag = 4'h0;
        end
        next_flag = next_flag & ~flag_clear_write_i;
        next_flag = next_flag | rise;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_flag_o <= FLAGS_RESET;
        end else begin
            request_flag_o <= next_flag;
        end
    end

endmodule : mif_edge_flags

/* File: logic/mif_controller.sv */
/*
 * Masked interrupt flag controller: twelve edge-triggered request flags in
 * three groups, three mask registers, a global enable and one request line
 * to the CPU core. Registers sit on a classic Wishbone slave.
 * Assumes all inputs are synchronous to clk_i and the master holds each
 * request until ack.
 */
`timescale 1ns/100ps
module mif_controller
    import mif_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // wishbone classic slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    output logic              wb_err_o,
    // peripheral request sources
    input  wire mif_sources_s sources_i,
    // core side
    input  wire logic         halt_entry_i,
    output logic              cpu_irq_o
);

    // ************************************************************
    // bus decode
    // ************************************************************
    logic [3:0] masks [NUM_GROUPS];
    logic [3:0] flags [NUM_GROUPS];
    logic [3:0] group_req [NUM_GROUPS];
    logic [3:0] read_clear;
    logic [3:0] clear_write [NUM_GROUPS];
    logic       global_irq_enable;
    logic       shared_compare;
    logic       access;
    logic       known;
    logic [3:0] flag_hit;
    logic [3:0] mask_hit;

    // map a byte address onto a flag group, or none
    function automatic logic [3:0] flag_group_hit(input logic [7:0] adr);
        flag_group_hit = 4'h0;
        case (adr)
            ADDR_PORT_FLAGS:     flag_group_hit = 4'h1;
            ADDR_TIMEBASE_FLAGS: flag_group_hit = 4'h2;
            ADDR_COUNTER_FLAGS:  flag_group_hit = 4'h4;
            default:             flag_group_hit = 4'h0;
        endcase
    endfunction : flag_group_hit

    function automatic logic [3:0] mask_group_hit(input logic [7:0] adr);
        mask_group_hit = 4'h0;
        case (adr)
            ADDR_PORT_MASKS:     mask_group_hit = 4'h1;
            ADDR_TIMEBASE_MASKS: mask_group_hit = 4'h2;
            ADDR_COUNTER_MASKS:  mask_group_hit = 4'h4;
            default:             mask_group_hit = 4'h0;
        endcase
    endfunction : mask_group_hit

    // one access per request: ack low in the cycle after it was given
    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    // decoded once as vectors, since a bit of a call result cannot be selected
    assign flag_hit = flag_group_hit(wb_adr_i);
    assign mask_hit = mask_group_hit(wb_adr_i);
    assign known  = (flag_hit != 4'h0) | (mask_hit != 4'h0)
                  | (wb_adr_i == ADDR_SYS_CONTROL);

    // ************************************************************
    // request routing
    // ************************************************************
    // both analogue requests share the timebase compare line; supply_check also drives counter bit 3
    assign shared_compare = sources_i.comparator | sources_i.supply_check;

    assign group_req[GRP_PORT]     = sources_i.port_input;
    assign group_req[GRP_TIMEBASE] = {sources_i.one_hertz, sources_i.fast_tick,
                                      sources_i.blink_tick, shared_compare};
    assign group_req[GRP_COUNTER]  = {sources_i.supply_check, sources_i.msec_counter,
                                      sources_i.counter_zero,
                                      sources_i.counter_match};

    // ************************************************************
    // flag groups, one per register; no priority between them
    // ************************************************************
    generate
        for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
            // read clear only on the accepted read cycle, the data left with ack
            assign read_clear[g] = access & ~wb_we_i & flag_hit[g];
            assign clear_write[g] = (access & wb_we_i & wb_sel_i[0]
                                     & flag_hit[g])
                                    ? wb_dat_i[3:0] : 4'h0;

            mif_edge_flags u_flags (
                .clk_i              (clk_i),
                .rst_i              (rst_i),
                .request_i          (group_req[g]),
                .request_mask_i     (masks[g]),
                .read_clear_i       (read_clear[g]),
                .flag_clear_write_i (clear_write[g]),
                .request_flag_o     (flags[g])
            );

            // mask registers, cleared by every reset
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    masks[g] <= MASKS_RESET;
                end else if (access & wb_we_i & wb_sel_i[0]
                             & mask_hit[g]) begin
                    masks[g] <= wb_dat_i[3:0];
                end
            end
        end
    endgenerate
    assign read_clear[3] = 1'b0;

    // ************************************************************
    // global enable
    // ************************************************************
    // halt entry wins over a same-cycle software write so wakeup stays armed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_enable <= GLOBAL_EN_RESET;
        end else if (halt_entry_i) begin
            global_irq_enable <= 1'b1;
        end else if (access & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADDR_SYS_CONTROL)) begin
            global_irq_enable <= wb_dat_i[GLOBAL_EN_BIT];
        end
    end

    // ************************************************************
    // cpu request
    // ************************************************************
    // flags stay until cleared, so a late request re-raises after service
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_o <= 1'b0;
        end else begin
            cpu_irq_o <= global_irq_enable
                         & ((flags[0] | flags[1] | flags[2]) != 4'h0);
        end
    end

    // ************************************************************
    // bus answer: one wait-free cycle, ack or err
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access & known;
            wb_err_o <= access & ~known;
            wb_dat_o <= 32'h0000_0000;
            if (access & ~wb_we_i) begin
                case (wb_adr_i)
                    ADDR_PORT_FLAGS:     wb_dat_o <= {28'h0, flags[GRP_PORT]};
                    ADDR_TIMEBASE_FLAGS: wb_dat_o <= {28'h0, flags[GRP_TIMEBASE]};
                    ADDR_COUNTER_FLAGS:  wb_dat_o <= {28'h0, flags[GRP_COUNTER]};
                    ADDR_PORT_MASKS:     wb_dat_o <= {28'h0, masks[GRP_PORT]};
                    ADDR_TIMEBASE_MASKS: wb_dat_o <= {28'h0, masks[GRP_TIMEBASE]};
                    ADDR_COUNTER_MASKS:  wb_dat_o <= {28'h0, masks[GRP_COUNTER]};
                    ADDR_SYS_CONTROL:    wb_dat_o <= {31'h0, global_irq_enable};
                    default:             wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : mif_controller

/* File: dv/mif_controller_monitor.sv */
/* port checker for the masked interrupt flag controller.
   assumes it is bound to mif_controller and sees only its ports. */
`timescale 1ns/100ps
module mif_controller_monitor
    import mif_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    input  wire logic [31:0]  wb_dat_o,
    input  wire logic         wb_ack_o,
    input  wire logic         wb_err_o,
    input  wire mif_sources_s sources_i,
    input  wire logic         halt_entry_i,
    input  wire logic         cpu_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic mapped;
    logic en_seen;
    // the enable is internal, so track whether anything could have set it
    assign mapped = wb_adr_i inside {ADDR_PORT_FLAGS, ADDR_TIMEBASE_FLAGS, ADDR_COUNTER_FLAGS,
        ADDR_PORT_MASKS, ADDR_TIMEBASE_MASKS, ADDR_COUNTER_MASKS, ADDR_SYS_CONTROL};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_seen <= 1'b0;
        end else if (halt_entry_i || (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == ADDR_SYS_CONTROL && wb_dat_i[0])) begin
            en_seen <= 1'b1;
        end
    end
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    ack_answer_a: assert property (take_s ##0 mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked next cycle");
    err_answer_a: assert property (take_s ##0 !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    err_pulse_a: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held too long");
    ack_cause_a: assert property ((wb_ack_o || wb_err_o)
        |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o))
        else $error("answer without request");
    dat_idle_a: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("read data outside read ack");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !cpu_irq_o && !wb_ack_o)
        else $error("outputs active after reset");
    irq_enable_a: assert property (cpu_irq_o |-> en_seen)
        else $error("cpu request without enable");
endmodule : mif_controller_monitor

/* File: dv/mif_source_model.sv */
/* peripheral request cells: each line follows its fire bit one cycle later.
   assumes fire bits come from the bench on rising edges. */
`timescale 1ns/100ps
module mif_source_model
    import mif_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [11:0]  fire_i,
    output mif_sources_s      sources_o
);
    // a one-cycle fire gives one clean rising edge on each line whose fire bit is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sources_o <= '0;
        end else begin
            sources_o <= mif_sources_s'(fire_i);
        end
    end
endmodule : mif_source_model

/* File: dv/masked_interrupt_flags_tb_top.sv */
/* self-checking bench for the flag controller with wishbone tasks.
   assumes the monitor and the source model are compiled first. */
`timescale 1ns/100ps
module masked_interrupt_flags_tb_top;
    import mif_pkg::*;
    logic         clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0;
    logic [7:0]   adr = 8'h00;
    logic [31:0]  wdat = 32'h0, rdat, q;
    logic [11:0]  fire = 12'h000, m, b;
    logic         ack, err, irq, last_err;
    mif_sources_s src;
    int           errors = 0, comparisons = 0;
    always #20 clk = ~clk;
    mif_source_model src_model (.clk_i(clk), .rst_i(rst), .fire_i(fire), .sources_o(src));
    mif_controller uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .sources_i(src), .halt_entry_i(halt),
        .cpu_irq_o(irq));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // holds the request until ack or err is sampled, then idles one cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 28'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (!(ack || err) && n < 20);
        q = rdat;
        last_err = err;
        chk("bus answer", {31'h0, ack | err}, 32'h1);
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [3:0] e);
        bus(1'b0, a, 4'h0);
        chk($sformatf("reg %h", a), q, {28'h0, e});
    endtask : rd
    task automatic pulse(input logic [11:0] v);
        fire <= v;
        @(posedge clk);
        fire <= 12'h000;
        repeat (3) @(posedge clk);
    endtask : pulse
    // expected flag nibble per group; supply shares the compare bit
    function automatic logic [3:0] grp(input int g, input logic [11:0] s);
        case (g)
            0: return s[11:8];
            1: return {s[7:5], s[4] | s[3]};
            default: return s[3:0];
        endcase
    endfunction : grp
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        #(40 * 20000);
        errors++;
        close_out();
    end
    initial begin
        void'($urandom(71));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int g = 0; g < 7; g++) rd(8'(4 * g), 4'h0);
        bus(1'b0, 8'h1C, 4'h0);
        chk("unmapped err", {31'h0, last_err}, 32'h1);
        $display("test reset done");
        // random masks and sources, enable stays off meanwhile
        for (int i = 0; i < 8; i++) begin
            m = 12'($urandom);
            b = 12'($urandom);
            for (int g = 0; g < 3; g++) bus(1'b1, 8'h0C + 8'(4 * g), m[11 - 4 * g -: 4]);
            pulse(b);
            for (int g = 0; g < 3; g++) begin
                rd(8'h0C + 8'(4 * g), m[11 - 4 * g -: 4]);
                rd(8'(4 * g), grp(g, b) & m[11 - 4 * g -: 4]);
                rd(8'(4 * g), 4'h0);
            end
        end
        $display("test random done");
        for (int g = 0; g < 3; g++) bus(1'b1, 8'h0C + 8'(4 * g), 4'hF);
        fire <= 12'h800;
        repeat (3) @(posedge clk);
        rd(8'h00, 4'h8);
        repeat (3) @(posedge clk);
        fire <= 12'h000;
        repeat (3) @(posedge clk);
        rd(8'h00, 4'h0);
        pulse(12'hF00);
        bus(1'b1, 8'h00, 4'h5);
        bus(1'b1, 8'h00, 4'h0);
        rd(8'h00, 4'hA);
        $display("test clear done");
        pulse(12'h010);
        chk("irq off", {31'h0, irq}, 32'h0);
        rd(8'h04, 4'h1);
        pulse(12'h001);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq wake", {31'h0, irq}, 32'h1);
        rd(8'h18, 4'h1);
        bus(1'b0, 8'h08, 4'h0); // software keeps this copy and picks the group itself
        chk("service copy", q, 32'h1);
        pulse(12'h004);
        chk("irq pending", {31'h0, irq}, 32'h1);
        rd(8'h08, 4'h4);
        @(posedge clk);
        chk("irq idle", {31'h0, irq}, 32'h0);
        $display("test irq done");
        // the source edge lands on the very edge that takes the clear
        for (int w = 0; w < 2; w++) begin
            fire <= 12'h400;
            @(posedge clk);
            fire <= 12'h000;
            bus(1'(w), 8'h00, 4'hF);
            rd(8'h00, 4'h4);
        end
        $display("test race done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int g = 3; g < 7; g++) rd(8'(4 * g), 4'h0);
        $display("test rereset done");
        close_out();
    end
endmodule : masked_interrupt_flags_tb_top
bind mif_controller mif_controller_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .sources_i(sources_i), .halt_entry_i(halt_entry_i),
    .cpu_irq_o(cpu_irq_o));
